// ### shared/ucd_defs.vh
// Register map, field positions and reset values of the serial port block.
`ifndef UCD_DEFS_VH
`define UCD_DEFS_VH
// Register byte offsets on the APB bus.
`define UCD_OFF_CTRL1   8'h00
`define UCD_OFF_CTRL2   8'h04
`define UCD_OFF_CTRL3   8'h08
`define UCD_OFF_DATA    8'h0C
`define UCD_OFF_BAUDH   8'h10
`define UCD_OFF_BAUDL   8'h14
`define UCD_OFF_FRAC    8'h18
`define UCD_OFF_STATUS  8'h1C
// First control register fields.
`define UCD_C1_GLOBAL   7
`define UCD_C1_NINE     6
`define UCD_C1_TX9      0
// Second control register fields.
`define UCD_C2_TXON     7
`define UCD_C2_RXON     6
`define UCD_C2_STOP_COUNT_SELECT    5
`define UCD_C2_ADDR     4
`define UCD_C2_WAKE     3
`define UCD_C2_RIE      2
`define UCD_C2_TX_IDLE_IRQ_ON     1
`define UCD_C2_TX_EMPTY_IRQ_ON     0
// Third control register field.
`define UCD_C3_SWM      0
// Fraction register fields.
`define UCD_FR_MOD_HI   5
`define UCD_FR_MOD_LO   3
`define UCD_FR_RANGE    2
// Status register fields.
`define UCD_ST_EMPTY    0
`define UCD_ST_IDLE     1
`define UCD_ST_READY    2
`define UCD_ST_OVR      3
`define UCD_ST_RX9      4
`define UCD_ST_WAKE     5
`define UCD_ST_IRQ      6
// Reset values.
`define UCD_RST_BYTE    8'h00
`define UCD_RST_WORD    32'h00000000
// Frame bit counts: start plus eight data plus one stop.
`define UCD_FRAME_BASE  4'hA
`define UCD_RX_LAST8    4'h9
`endif

// ### verilog/ucd_uart.v
// Serial port control, baud divider and character engine with APB registers.
//
// Overview of operation
// - Clearing transmitter enable aborts sending, empties the buffer, floats TX.
// - TX pin is driven only while transmitter and port enables are both set.
// - Clearing receiver enable aborts reception, clears ready and overrun flags; RX/TX is then driven if single-wire and transmitter are on.
// - Receiver owns RX/TX only while receiver and port enables are both set.
// - Stop select zero sends one stop bit, one sends two.
// - With address detection, a word whose top bit is one is kept and signalled.
// - With address detection, a word whose top bit is zero is dropped silently.
// - Port clock off and wake bit set: falling RX/TX edge raises wake request.
// - No wake request while port clock runs or wake bit is clear.
// - Receive enable lets overrun or data-ready raise the port request.
// - Idle enable lets the transmitter idle flag raise the port request.
// - Empty enable lets the transmit empty flag raise the port request.
// - Single-wire off uses RX/TX only for receiving; on, per enables.
// - Single-wire with both enables set keeps RX/TX as receiver input.
// - One shared data byte: writes send, reads return the received byte.
// - Bit period comes from the sixteen-bit divisor plus modulation eighths.
// - Port disable empties buffers, resets counters, clears receive flags and both engine enables.
// - Modulation adds into an accumulator; each carry adds one clock to a bit.
`timescale 1ns/1ps
`include "ucd_defs.vh"

// Bit timer: counts one bit period, stretched by modulation carries.
module ucd_bit_timer #(
    parameter DW = 16
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          run,
    input  wire [DW-1:0] divisor,
    input  wire [2:0]    fraction_modulation,
    output wire          tick,
    output wire          mid
);
    reg  [DW:0] cnt_reg;
    reg  [2:0]  acc_reg;
    reg         carry_reg;
    wire [DW:0] len;
    wire [3:0]  sum;

    // Current bit length is the divisor plus the carry won for this bit.
    assign len  = {1'b0, divisor} + {{DW{1'b0}}, carry_reg};
    assign sum  = {1'b0, acc_reg} + {1'b0, fraction_modulation};
    assign tick = run && (cnt_reg == len - {{DW{1'b0}}, 1'b1});
    assign mid  = run && (cnt_reg == {1'b0, len[DW:1]});

    // The accumulator restarts with each frame so the first bit has no carry.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg   <= {(DW+1){1'b0}};
            acc_reg   <= 3'h0;
            carry_reg <= 1'b0;
        end
        else if (!run)
        begin
            cnt_reg   <= {(DW+1){1'b0}};
            acc_reg   <= fraction_modulation;
            carry_reg <= 1'b0;
        end
        else if (tick)
        begin
            cnt_reg   <= {(DW+1){1'b0}};
            acc_reg   <= sum[2:0];
            carry_reg <= sum[3];
        end
        else
        begin
            cnt_reg <= cnt_reg + {{DW{1'b0}}, 1'b1};
        end
    end
endmodule // ucd_bit_timer

// Top: APB register slave, transmitter, receiver and pin control.
module ucd_uart #(
    parameter DIV_W = 16
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        rxtx_in,
    output reg         rxtx_out,
    output reg         rxtx_oe,
    output reg         tx_out,
    output reg         tx_oe,
    input  wire        port_clock_off,
    output reg         irq_request
);
    reg              port_global_on_reg;
    reg              nine_bit_select_reg;
    reg              tx_ninth_reg;
    reg  [7:0]       serial_control_two_reg;
    reg              single_wire_on_reg;
    reg  [7:0]       baud_divisor_high_reg;
    reg  [7:0]       baud_divisor_low_reg;
    reg  [DIV_W-1:0] divisor_reg;
    reg  [2:0]       fraction_modulation_reg;
    reg              divisor_range_select_reg;
    reg              overrun_flag_reg;
    reg              receive_ready_flag_reg;
    reg              received_ninth_bit_reg;
    reg              wake_flag_reg;
    reg  [7:0]       rx_data_reg;
    reg  [8:0]       tx_buf_reg;
    reg              tx_full_reg;
    reg  [11:0]      tx_shift_reg;
    reg  [3:0]       tx_left_reg;
    reg              tx_busy_reg;
    reg              rx_busy_reg;
    reg  [3:0]       rx_cnt_reg;
    reg  [8:0]       rx_shift_reg;
    reg              rx_s1_reg;
    reg              rx_s2_reg;
    reg              rx_s3_reg;
    reg              off_s1_reg;
    reg              off_s2_reg;
    reg  [31:0]      rd_next;
    reg              hit_next;
    wire             access;
    wire             wr;
    wire             rd;
    wire             tx_en;
    wire             rx_en;
    wire             tx_idle;
    wire             tx_tick;
    wire             rx_mid;
    wire             rx_fall;
    wire [3:0]       rx_last;
    wire             rx_addr_bit;
    wire [7:0]       rx_word;
    wire [7:0]       c2;

    assign c2 = serial_control_two_reg;

    // A request is taken at the edge where the access phase sees pready.
    assign access = psel && penable && pready;
    assign wr     = access && pwrite;
    assign rd     = access && !pwrite;

    // Engines run only with the port enabled and their own enable set.
    assign tx_en   = port_global_on_reg && c2[`UCD_C2_TXON];
    assign rx_en   = port_global_on_reg && c2[`UCD_C2_RXON];
    assign tx_idle = !tx_full_reg && !tx_busy_reg;
    assign rx_fall = rx_s3_reg && !rx_s2_reg;

    // The address bit is the top received bit in both word sizes.
    assign rx_last     = nine_bit_select_reg ? `UCD_FRAME_BASE : `UCD_RX_LAST8;
    assign rx_addr_bit = rx_shift_reg[8];
    assign rx_word     = nine_bit_select_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];

    // Separate timers let the receiver resync on each start edge.
    ucd_bit_timer #(
        .DW(DIV_W)
    ) u_tx_timer (
        .clk     (clk),
        .rst     (rst),
        .run     (tx_busy_reg),
        .divisor (divisor_reg),
        .fraction_modulation    (fraction_modulation_reg),
        .tick    (tx_tick),
        .mid     ()
    );

    ucd_bit_timer #(
        .DW(DIV_W)
    ) u_rx_timer (
        .clk     (clk),
        .rst     (rst),
        .run     (rx_busy_reg),
        .divisor (divisor_reg),
        .fraction_modulation    (fraction_modulation_reg),
        .tick    (),
        .mid     (rx_mid)
    );

    // Two-stage synchronisers for the line and the clock-off indication.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_s1_reg  <= 1'b1;
            rx_s2_reg  <= 1'b1;
            rx_s3_reg  <= 1'b1;
            off_s1_reg <= 1'b0;
            off_s2_reg <= 1'b0;
        end
        else
        begin
            rx_s1_reg  <= rxtx_in;
            rx_s2_reg  <= rx_s1_reg;
            rx_s3_reg  <= rx_s2_reg;
            off_s1_reg <= port_clock_off;
            off_s2_reg <= off_s1_reg;
        end
    end

    // Read data selection and address decode.
    always @*
    begin
        rd_next  = `UCD_RST_WORD;
        hit_next = 1'b1;
        case (paddr)
            `UCD_OFF_CTRL1:
                rd_next[7:0] = {port_global_on_reg, nine_bit_select_reg,
                                5'h00, tx_ninth_reg};
            `UCD_OFF_CTRL2:  rd_next[7:0] = c2;
            `UCD_OFF_CTRL3:  rd_next[`UCD_C3_SWM] = single_wire_on_reg;
            `UCD_OFF_DATA:   rd_next[7:0] = rx_data_reg;
            `UCD_OFF_BAUDH:  rd_next[7:0] = baud_divisor_high_reg;
            `UCD_OFF_BAUDL:  rd_next[7:0] = baud_divisor_low_reg;
            `UCD_OFF_FRAC:
            begin
                rd_next[`UCD_FR_MOD_HI:`UCD_FR_MOD_LO] = fraction_modulation_reg;
                rd_next[`UCD_FR_RANGE] = divisor_range_select_reg;
            end
            `UCD_OFF_STATUS:
                rd_next[7:0] = {1'b0, irq_request, wake_flag_reg,
                                received_ninth_bit_reg, overrun_flag_reg,
                                receive_ready_flag_reg, tx_idle, !tx_full_reg};
            default:         hit_next = 1'b0;
        endcase
    end

    // APB answer: one wait state, then pready with data or an error.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `UCD_RST_WORD;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !hit_next;
            if (psel && penable && !pready)
                prdata <= pwrite ? `UCD_RST_WORD : rd_next;
        end
    end

    // Control registers; port disable clears both engine enables.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_global_on_reg       <= 1'b0;
            nine_bit_select_reg      <= 1'b0;
            tx_ninth_reg             <= 1'b0;
            serial_control_two_reg   <= `UCD_RST_BYTE;
            single_wire_on_reg       <= 1'b0;
            baud_divisor_high_reg    <= `UCD_RST_BYTE;
            baud_divisor_low_reg     <= `UCD_RST_BYTE;
            divisor_reg              <= {DIV_W{1'b0}};
            fraction_modulation_reg  <= 3'h0;
            divisor_range_select_reg <= 1'b0;
        end
        else
        begin
            if (wr && paddr == `UCD_OFF_CTRL1)
            begin
                port_global_on_reg  <= pwdata[`UCD_C1_GLOBAL];
                nine_bit_select_reg <= pwdata[`UCD_C1_NINE];
                tx_ninth_reg        <= pwdata[`UCD_C1_TX9];
            end
            if (wr && paddr == `UCD_OFF_CTRL2)
                serial_control_two_reg <= pwdata[7:0];
            else if (!port_global_on_reg)
            begin
                serial_control_two_reg[`UCD_C2_TXON] <= 1'b0;
                serial_control_two_reg[`UCD_C2_RXON] <= 1'b0;
            end
            if (wr && paddr == `UCD_OFF_CTRL3)
                single_wire_on_reg <= pwdata[`UCD_C3_SWM];
            if (wr && paddr == `UCD_OFF_BAUDL)
                baud_divisor_low_reg <= pwdata[7:0];
            if (wr && paddr == `UCD_OFF_BAUDH)
            begin
                baud_divisor_high_reg <= pwdata[7:0];
                divisor_reg <= {pwdata[7:0], baud_divisor_low_reg};
            end
            if (wr && paddr == `UCD_OFF_FRAC)
            begin
                fraction_modulation_reg  <= pwdata[`UCD_FR_MOD_HI:`UCD_FR_MOD_LO];
                divisor_range_select_reg <= pwdata[`UCD_FR_RANGE];
            end
        end
    end

    // Transmit buffer and shifter; a disabled transmitter drops everything.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_buf_reg   <= 9'h000;
            tx_full_reg  <= 1'b0;
            tx_shift_reg <= 12'hFFF;
            tx_left_reg  <= 4'h0;
            tx_busy_reg  <= 1'b0;
        end
        else if (!tx_en)
        begin
            tx_full_reg  <= 1'b0;
            tx_busy_reg  <= 1'b0;
            tx_shift_reg <= 12'hFFF;
            tx_left_reg  <= 4'h0;
        end
        else
        begin
            if (!tx_busy_reg && tx_full_reg)
            begin
                tx_full_reg  <= 1'b0;
                tx_busy_reg  <= 1'b1;
                tx_shift_reg <= {2'b11, nine_bit_select_reg ? tx_buf_reg[8] : 1'b1,
                                 tx_buf_reg[7:0], 1'b0};
                tx_left_reg  <= `UCD_FRAME_BASE
                              + {3'h0, nine_bit_select_reg}
                              + {3'h0, c2[`UCD_C2_STOP_COUNT_SELECT]};
            end
            else if (tx_tick)
            begin
                tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                tx_left_reg  <= tx_left_reg - 4'h1;
                if (tx_left_reg == 4'h1)
                    tx_busy_reg <= 1'b0;
            end
            if (wr && paddr == `UCD_OFF_DATA)
            begin
                tx_buf_reg  <= {tx_ninth_reg, pwdata[7:0]};
                tx_full_reg <= 1'b1;
            end
        end
    end

    // Receiver: start edge, mid-bit samples, address filter and overrun.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_busy_reg            <= 1'b0;
            rx_cnt_reg             <= 4'h0;
            rx_shift_reg           <= 9'h000;
            overrun_flag_reg       <= 1'b0;
            receive_ready_flag_reg <= 1'b0;
            received_ninth_bit_reg <= 1'b0;
        end
        else if (!rx_en)
        begin
            rx_busy_reg            <= 1'b0;
            rx_cnt_reg             <= 4'h0;
            overrun_flag_reg       <= 1'b0;
            receive_ready_flag_reg <= 1'b0;
        end
        else
        begin
            if (rd && paddr == `UCD_OFF_DATA)
            begin
                receive_ready_flag_reg <= 1'b0;
                overrun_flag_reg       <= 1'b0;
            end
            if (!rx_busy_reg)
            begin
                rx_cnt_reg <= 4'h0;
                if (rx_fall)
                    rx_busy_reg <= 1'b1;
            end
            else if (rx_mid)
            begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
                if (rx_cnt_reg == 4'h0 && rx_s2_reg)
                    rx_busy_reg <= 1'b0;
                else if (rx_cnt_reg != rx_last)
                    rx_shift_reg <= {rx_s2_reg, rx_shift_reg[8:1]};
                else
                begin
                    rx_busy_reg <= 1'b0;
                    if (c2[`UCD_C2_ADDR] && !rx_addr_bit)
                        rx_busy_reg <= 1'b0;
                    else if (receive_ready_flag_reg
                             && !(rd && paddr == `UCD_OFF_DATA))
                        overrun_flag_reg <= 1'b1;
                    else
                    begin
                        receive_ready_flag_reg <= 1'b1;
                        received_ninth_bit_reg <= rx_shift_reg[8];
                    end
                end
            end
        end
    end

    // Received byte keeps no reset value.
    always @(posedge clk)
    begin
        if (rx_en && rx_busy_reg && rx_mid && rx_cnt_reg == rx_last
                 && !(c2[`UCD_C2_ADDR] && !rx_addr_bit)
                 && !(receive_ready_flag_reg && !(rd && paddr == `UCD_OFF_DATA)))
            rx_data_reg <= rx_word;
    end

    // Wake request: only with the port clock off and the wake bit set.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            wake_flag_reg <= 1'b0;
        else if (off_s2_reg && c2[`UCD_C2_WAKE] && rx_fall)
            wake_flag_reg <= 1'b1;
        else if (wr && paddr == `UCD_OFF_STATUS && pwdata[`UCD_ST_WAKE])
            wake_flag_reg <= 1'b0;
    end

    // Port request combines each flag gated by its enable; receive enable gates overrun, ready and wake.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_request <= 1'b0;
        else
            irq_request <= (c2[`UCD_C2_RIE] && (overrun_flag_reg
                                                 || receive_ready_flag_reg))
                         || (c2[`UCD_C2_TX_IDLE_IRQ_ON] && tx_idle)
                         || (c2[`UCD_C2_TX_EMPTY_IRQ_ON] && !tx_full_reg)
                         || (c2[`UCD_C2_RIE] && wake_flag_reg);
    end

    // Pin drive: TX from the shifter; RX/TX transmits only in single-wire.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_out   <= 1'b1;
            tx_oe    <= 1'b0;
            rxtx_out <= 1'b1;
            rxtx_oe  <= 1'b0;
        end
        else
        begin
            tx_out   <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
            tx_oe    <= tx_en;
            rxtx_out <= tx_busy_reg ? tx_shift_reg[0] : 1'b1;
            rxtx_oe  <= single_wire_on_reg && tx_en
                        && !c2[`UCD_C2_RXON];
        end
    end
endmodule // ucd_uart

// ### verification/ucd_uart_props.sv
// Concurrent checks on the bus and pin ports of the serial port block.
`timescale 1ns/1ps
`include "ucd_defs.vh"
module ucd_uart_props (
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        rxtx_oe,
    input wire        tx_out,
    input wire        tx_oe,
    input wire        irq_request
);
    reg  port_on_reg;
    wire done = psel && penable && pready && pwrite;
    wire wc1  = done && paddr == `UCD_OFF_CTRL1;
    wire wc2  = done && paddr == `UCD_OFF_CTRL2;
    wire wc3  = done && paddr == `UCD_OFF_CTRL3;
    wire wdat = done && paddr == `UCD_OFF_DATA;

    // Shadow of the port enable, so that TX drive can be tied to both enables.
    always @(posedge clk or posedge rst)
        if (rst)
            port_on_reg <= 1'b0;
        else if (wc1)
            port_on_reg <= pwdata[`UCD_C1_GLOBAL];

    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_tx_off: assert property (wc2 && !pwdata[7] |-> ##[1:3] !tx_oe)
        else $error("TX pin driven after transmitter off.");
    a_port_off: assert property (wc1 && !pwdata[7] |-> ##[1:3] (!tx_oe && !rxtx_oe))
        else $error("Pins driven after port off.");
    a_tx_drive: assert property (wc2 && pwdata[7] && port_on_reg |-> ##[1:3] tx_oe)
        else $error("TX pin not driven with both enables.");
    a_rx_owns: assert property (wc2 && pwdata[6] |-> ##2 (!rxtx_oe) [*2])
        else $error("RX/TX driven while receiver on.");
    a_swm_input: assert property (wc3 && !pwdata[0] |-> ##2 (!rxtx_oe) [*2])
        else $error("RX/TX driven without single wire.");
    a_irq_masked: assert property (wc2 && pwdata[2:0] == 3'h0 |-> ##2 (!irq_request) [*2])
        else $error("Request raised with all enables off.");
    a_data_drop: assert property (wdat && !tx_oe |-> ##1 tx_out [*8])
        else $error("Character sent while transmitter off.");
    a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("Ready outside access or longer than one cycle.");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("Error response without ready.");

    c_two_stop_count_select: cover property (wc2 && pwdata[5]);
    c_tx_on: cover property ($rose(tx_oe));
    c_irq: cover property ($rose(irq_request));
    c_wire: cover property ($rose(rxtx_oe));
endmodule // ucd_uart_props

// ### verification/ucd_peer.sv
// Remote serial node: sends frames on RX/TX and logs every TX pin change.
`timescale 1ns/1ps
module ucd_peer #(
    parameter BIT_CYC = 8
) (
    input  wire clk,
    input  wire tx_pin,
    output reg  line_drive
);
    integer cyc     = 0;
    reg     tx_last = 1'b1;
    integer edge_q[$];

    // Edge times let the bench measure bit, frame and stop lengths.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        tx_last <= tx_pin;
        if (tx_pin !== tx_last)
            edge_q.push_back(cyc);
    end

    // Sends one frame LSB first with one stop bit, then idles high.
    task send(input [7:0] d);
        integer   i;
        reg [9:0] f;
        begin
            f = {1'b1, d, 1'b0};
            for (i = 0; i < 10; i = i + 1)
            begin
                line_drive <= f[i];
                repeat (BIT_CYC) @(posedge clk);
            end
        end
    endtask

    // The line idles high between frames.
    initial
        line_drive = 1'b1;
endmodule // ucd_peer

// ### verification/ucd_uart_test.sv
// Self-checking bench for the serial port block and a remote node.
`timescale 1ns/1ps
`include "ucd_defs.vh"
bind ucd_uart ucd_uart_props ucd_uart_props_inst (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .rxtx_oe, .tx_out, .tx_oe, .irq_request);
module ucd_uart_test;
    reg         clk            = 1'b0;
    reg         rst            = 1'b1;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    reg         port_clock_off;
    reg         err;
    reg  [31:0] r;
    integer     mismatches     = 0;
    integer     checks         = 0;
    wire [31:0] prdata;
    wire        pready, pslverr, rxtx_out, rxtx_oe, tx_out, tx_oe, irq_request, drive;
    // The TX pin has a pull-up; RX/TX carries whichever side drives it.
    wire        tx_line        = tx_oe ? tx_out : 1'b1;
    wire        rxtx_line      = rxtx_oe ? rxtx_out : drive;

    ucd_uart ucd_uart_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rxtx_in(rxtx_line), .rxtx_out, .rxtx_oe, .tx_out, .tx_oe,
        .port_clock_off, .irq_request);
    ucd_peer ucd_peer_inst (.clk, .tx_pin(tx_line), .line_drive(drive));

    always #12.5 clk = ~clk;

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: got %0h, expected %0h", $time, got, exp);
            end
        end
    endtask

    // One APB transfer; the wait is bounded so a missing ready shows as a mismatch.
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            n = 0;
            @(posedge clk);
            while (pready !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                n = n + 1;
            end
            chk(pready, 1'b1);
            r = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input [7:0] a, input [7:0] d); apb(1'b1, a, {24'h000000, d}); endtask
    task rd(input [7:0] a); apb(1'b0, a, 32'h00000000); endtask
    task c2(input [7:0] d); wr(`UCD_OFF_CTRL2, d); endtask
    task cyc(input integer n); repeat (n) @(posedge clk); endtask

    // Sends two characters back to back and measures the first frame and its stop.
    task tx_pair(input [7:0] c, input integer lo, input integer hi, input integer gl);
        integer s;
        integer g;
        begin
            c2(c);
            ucd_peer_inst.edge_q.delete();
            wr(`UCD_OFF_DATA, 8'h55);
            wr(`UCD_OFF_DATA, 8'h55);
            cyc(300);
            chk(ucd_peer_inst.edge_q.size(), 20);
            s = ucd_peer_inst.edge_q[9] - ucd_peer_inst.edge_q[0];
            g = ucd_peer_inst.edge_q[10] - ucd_peer_inst.edge_q[9];
            chk(s >= lo && s <= hi, 1'b1);
            chk(g >= gl && g <= gl + 2, 1'b1);
        end
    endtask

    task t_regs;
        begin
            rd(`UCD_OFF_CTRL2);
            chk(r, `UCD_RST_WORD);
            rd(`UCD_OFF_CTRL3);
            chk(r, `UCD_RST_WORD);
            rd(`UCD_OFF_BAUDH);
            chk(r, `UCD_RST_WORD);
            rd(8'h40);
            chk({err, r[30:0]}, 32'h80000000);
        end
    endtask

    task t_tx;
        begin
            wr(`UCD_OFF_FRAC, 8'h04);
            wr(`UCD_OFF_BAUDL, 8'h08);
            wr(`UCD_OFF_BAUDH, 8'h00);
            wr(`UCD_OFF_CTRL1, 8'h80);
            tx_pair(8'h80, 72, 72, 8);
            tx_pair(8'hA0, 72, 72, 16);
            wr(`UCD_OFF_FRAC, 8'h24);
            wr(`UCD_OFF_BAUDL, 8'h10);
            tx_pair(8'h80, 76, 77, 8);
            wr(`UCD_OFF_FRAC, 8'h04);
        end
    endtask

    task t_tx_irq;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                c2(8'h80 | (8'h01 << i));
                cyc(3);
                chk(irq_request, i < 2);
            end
        end
    endtask

    task t_wire;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                wr(`UCD_OFF_CTRL3, {7'h00, i < 3});
                c2(i == 1 ? 8'hC0 : i == 2 ? 8'h40 : 8'h80);
                cyc(3);
                chk(rxtx_oe, i == 0);
                if (i == 0)
                begin
                    wr(`UCD_OFF_DATA, 8'h00);
                    cyc(12);
                    chk(rxtx_out, 1'b0);
                end
            end
        end
    endtask

    task t_rx;
        begin
            c2(8'h54);
            ucd_peer_inst.send(8'h12);
            rd(`UCD_OFF_STATUS);
            chk({r[2], irq_request}, 2'h0);
            ucd_peer_inst.send(8'h92);
            rd(`UCD_OFF_STATUS);
            chk({r[2], irq_request}, 2'h3);
            rd(`UCD_OFF_DATA);
            chk(r, 32'h00000092);
            cyc(3);
            chk(irq_request, 1'b0);
            c2(8'h50);
            ucd_peer_inst.send(8'h92);
            cyc(4);
            chk(irq_request, 1'b0);
            c2(8'h10);
            rd(`UCD_OFF_STATUS);
            chk(r[2], 1'b0);
        end
    endtask

    task t_wake;
        begin
            c2(8'h0C);
            ucd_peer_inst.send(8'hFF);
            rd(`UCD_OFF_STATUS);
            chk(r[5], 1'b0);
            port_clock_off <= 1'b1;
            cyc(4);
            ucd_peer_inst.send(8'hFF);
            rd(`UCD_OFF_STATUS);
            chk({r[5], irq_request}, 2'h3);
            wr(`UCD_OFF_STATUS, 8'h20);
            c2(8'h04);
            ucd_peer_inst.send(8'hFF);
            rd(`UCD_OFF_STATUS);
            chk({r[5], irq_request}, 2'h0);
            port_clock_off <= 1'b0;
        end
    endtask

    // Aborts a frame mid-way; nothing pending may come out after re-enabling.
    task t_abort;
        begin
            c2(8'h80);
            wr(`UCD_OFF_DATA, 8'h00);
            cyc(20);
            c2(8'h00);
            cyc(2);
            chk(tx_oe, 1'b0);
            wr(`UCD_OFF_DATA, 8'h00);
            c2(8'h80);
            ucd_peer_inst.edge_q.delete();
            cyc(100);
            chk(ucd_peer_inst.edge_q.size(), 0);
            rd(`UCD_OFF_STATUS);
            chk(r[1:0], 2'h3);
            c2(8'hC4);
            wr(`UCD_OFF_CTRL1, 8'h00);
            rd(`UCD_OFF_CTRL2);
            chk(r, 32'h00000004);
            rd(`UCD_OFF_STATUS);
            chk(r[1:0], 2'h3);
            c2(8'h80);
            cyc(3);
            chk(tx_oe, 1'b0);
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // Main sequence: reset for ten cycles, then every scenario in turn.
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, port_clock_off} <= 44'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_tx;
        t_tx_irq;
        t_wire;
        t_rx;
        t_wake;
        t_abort;
        summarize;
    end

    // Watchdog: the scenarios need some 1800 cycles; 20000 means a hang.
    initial
    begin
        #500000;
        mismatches = mismatches + 1;
        summarize;
    end
endmodule // ucd_uart_test
